// >>> logic/acc_pkg.sv
// acc_pkg: shared constants and types of the conversion mode control
// assumes a 10 MHz system clock and a 1.024 MHz converter reference clock
package acc_pkg;

    // clock rates, in kHz, used to scale converter-clock times into sys_clk cycles
    localparam int CLK_KHZ = 10000;
    localparam int OSC_KHZ = 1024;

    // first conversion starts 28.5 converter clocks after the start command
    localparam int START_DLY_HALF_TCLK = 57;
    localparam int START_DLY_CYC = (START_DLY_HALF_TCLK * CLK_KHZ + 2 * OSC_KHZ - 1) / (2 * OSC_KHZ);

    // conversion times per data-rate code, in converter clocks
    localparam int CONT_TCLK_20   = 51192;
    localparam int CONT_TCLK_90   = 11532;
    localparam int CONT_TCLK_330  = 3116;
    localparam int CONT_TCLK_1000 = 1036;
    localparam int SS_TCLK_20     = 51213;
    localparam int SS_TCLK_90     = 11557;
    localparam int SS_TCLK_330    = 3141;
    localparam int SS_TCLK_1000   = 1061;

    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // command codes, one byte each
    localparam logic [7:0] CMD_RESET = 8'h06;
    localparam logic [7:0] CMD_START = 8'h08;
    localparam logic [7:0] CMD_PDOWN = 8'h02;
    localparam logic [7:0] CMD_RDATA = 8'h10;
    localparam logic [7:0] CMD_RREG  = 8'h20;
    localparam logic [7:0] CMD_WREG  = 8'h40;

    // configuration layout and value after reset
    typedef struct packed {
        logic [2:0] inputSel;   // input_select_field
        logic       gainFour;   // 0: unity, 1: gain of four
        logic [1:0] rate;       // 0:20 1:90 2:330 3:1000 SPS
        logic       contMode;   // 0: single-shot, 1: continuous
        logic       extRef;     // reference source select
    } acc_cfg_t;

    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] SEL_FIRST_SINGLE = 3'h3;
    localparam logic [2:0] SEL_LAST_SINGLE  = 3'h6;

    // input routing codes: 0..3 pins, 4 mid supply, 5 none
    localparam logic [2:0] IN_MID  = 3'h4;
    localparam logic [2:0] IN_NONE = 3'h5;

    // analog front-end steering
    typedef struct packed {
        logic [2:0] posSel;     // positive_converter_input source
        logic [2:0] negSel;     // negative_converter_input source
        logic       gndSwitch;  // ties negative input to analog_ground
        logic       gainFour;   // gain stage setting
        logic       extRef;     // reference source
    } acc_front_t;

    localparam int RESULT_W = 24;

endpackage

// >>> logic/acc_result_buffer.sv
// acc_result_buffer: one-word result store with registered read port
// assumes writer and reader share sys_clk; the whole word loads on a single edge
`timescale 1ns/1ns
module acc_result_buffer
    import acc_pkg::*;
(
    input  wire logic                sys_clk,  // system clock
    input  wire logic                nrst,     // async reset, active low
    input  wire logic                wrEn,     // store a finished result
    input  wire logic [RESULT_W-1:0] wrData,   // finished result
    output logic      [RESULT_W-1:0] rdData    // latest stored result
);

    // whole-word load: a reader never sees a mix of two conversions
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdData <= '0;
        end else if (wrEn) begin
            rdData <= wrData;
        end
    end

endmodule

// >>> logic/acc_control.sv
// acc_control: command decode, conversion sequencing and front-end steering
// assumes serial clock, data and frame pins arrive asynchronously to sys_clk
// and that the converter core presents a settled 24-bit code on coreData
`timescale 1ns/1ns

// Behaviour
// - one configuration register holds all setup
// - six commands accepted, others ignored
// - single-shot request gives exactly one conversion
// - after single-shot, return to low-power idle
// - continuous mode restarts conversion automatically
// - continuous interval follows data-rate field
// - result buffer loads whole word atomically
// - input select field picks both inputs
// - single-ended codes close ground switch
// - results are 24-bit codes from core
// - gain selectable between one and four
// - command latched at eighth falling edge
module acc_control
    import acc_pkg::*;
#(
    parameter int CONT_CYC_20   = CONT_TCLK_20 * CLK_KHZ / OSC_KHZ,    // continuous, 20 SPS
    parameter int CONT_CYC_90   = CONT_TCLK_90 * CLK_KHZ / OSC_KHZ,    // continuous, 90 SPS
    parameter int CONT_CYC_330  = CONT_TCLK_330 * CLK_KHZ / OSC_KHZ,   // continuous, 330 SPS
    parameter int CONT_CYC_1000 = CONT_TCLK_1000 * CLK_KHZ / OSC_KHZ,  // continuous, 1000 SPS
    parameter int SS_CYC_20     = SS_TCLK_20 * CLK_KHZ / OSC_KHZ,      // single-shot, 20 SPS
    parameter int SS_CYC_90     = SS_TCLK_90 * CLK_KHZ / OSC_KHZ,      // single-shot, 90 SPS
    parameter int SS_CYC_330    = SS_TCLK_330 * CLK_KHZ / OSC_KHZ,     // single-shot, 330 SPS
    parameter int SS_CYC_1000   = SS_TCLK_1000 * CLK_KHZ / OSC_KHZ     // single-shot, 1000 SPS
)
(
    input  wire logic                sys_clk,     // system clock, 10 MHz
    input  wire logic                nrst,        // async reset, active low
    input  wire logic                sclPin,      // serial clock pin
    input  wire logic                sdaPin,      // serial data pin
    input  wire logic                framePin,    // high while a bus transaction addresses us
    input  wire logic [RESULT_W-1:0] coreData,    // converter core code
    output acc_front_t               front,       // analog steering
    output logic                     convActive,  // converter powered and running
    output logic                     convStart,   // pulse: conversion begins
    output logic                     dataFresh,   // unread result waiting
    output logic [RESULT_W-1:0]      replyData,   // read-back word
    output logic                     replyValid   // pulse: replyData updated
);

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} acc_state_t;

    acc_state_t          state;
    acc_cfg_t            cfg;
    logic                runCont;
    logic [1:0]          runRate;
    logic [19:0]         timer;
    logic [2:0]          sclSync;
    logic [1:0]          sdaSync, frameSync;
    logic [3:0]          bitCount;
    logic [7:0]          shiftReg;
    logic                wantCfg;
    logic                byteDone;
    logic [7:0]          byteVal;
    logic                isCmd;
    logic                convDone;
    logic [RESULT_W-1:0] bufData;

    // code-to-routing decode: pins 0..3, mid supply, ground switch
    function automatic acc_front_t route(input acc_cfg_t c);
        acc_front_t f;
        f = '0;
        f.gainFour = c.gainFour;
        f.extRef   = c.extRef;
        case (c.inputSel)
            3'h0: begin f.posSel = 3'h0; f.negSel = 3'h1; end
            3'h1: begin f.posSel = 3'h2; f.negSel = 3'h3; end
            3'h2: begin f.posSel = 3'h1; f.negSel = 3'h2; end
            3'h7: begin f.posSel = IN_MID; f.negSel = IN_MID; end
            default: begin
                f.posSel = c.inputSel - SEL_FIRST_SINGLE;
                f.negSel = IN_NONE;
            end
        endcase
        f.gndSwitch = (c.inputSel >= SEL_FIRST_SINGLE) && (c.inputSel <= SEL_LAST_SINGLE);
        return f;
    endfunction

    // conversion length for a rate code in the given mode
    function automatic logic [19:0] convLen(input logic [1:0] r, input logic cont);
        logic [19:0] n;
        n = 20'h0;
        case (r)
            2'h0:    n = cont ? 20'(CONT_CYC_20)   : 20'(SS_CYC_20);
            2'h1:    n = cont ? 20'(CONT_CYC_90)   : 20'(SS_CYC_90);
            2'h2:    n = cont ? 20'(CONT_CYC_330)  : 20'(SS_CYC_330);
            default: n = cont ? 20'(CONT_CYC_1000) : 20'(SS_CYC_1000);
        endcase
        return n;
    endfunction

    // two flops before use; serial clock keeps a third for edge detection
    // clock and data reset to the pulled-up idle level, frame to its low idle level, so no false edge follows reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclSync   <= 3'h7;
            sdaSync   <= 2'h3;
            frameSync <= 2'h0;
        end else begin
            sclSync   <= {sclSync[1:0], sclPin};
            sdaSync   <= {sdaSync[0], sdaPin};
            frameSync <= {frameSync[0], framePin};
        end
    end

    // data shifts in on the rising serial clock edge, msb first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shiftReg <= 8'h00;
            bitCount <= 4'h0;
            byteDone <= 1'b0;
        end else begin
            byteDone <= 1'b0;
            if (!frameSync[1]) begin
                bitCount <= 4'h0;
            end else if (sclSync[1] && !sclSync[2]) begin
                shiftReg <= {shiftReg[6:0], sdaSync[1]};
            end else if (!sclSync[1] && sclSync[2]) begin
                if (bitCount == BITS_PER_BYTE - 4'h1) begin
                    bitCount <= 4'h0;
                    byteDone <= 1'b1;
                end else begin
                    bitCount <= bitCount + 4'h1;
                end
            end
        end
    end

    assign byteVal = shiftReg;
    assign isCmd   = byteDone && !wantCfg;

    // the single configuration register, written after a write command
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg     <= acc_cfg_t'(CFG_RESET);
            wantCfg <= 1'b0;
        end else if (byteDone && wantCfg) begin
            cfg     <= acc_cfg_t'(byteVal);
            wantCfg <= 1'b0;
        end else if (isCmd && byteVal == CMD_RESET) begin
            cfg     <= acc_cfg_t'(CFG_RESET);
        end else if (isCmd && byteVal == CMD_WREG) begin
            wantCfg <= 1'b1;
        end else if (!frameSync[1]) begin
            wantCfg <= 1'b0;   // a write cut short leaves the setup untouched
        end
    end

    assign convDone = (state == ST_CONV) && (timer == 20'h1);

    // sequencer; timing is counted from the command latch
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            timer     <= 20'h0;
            runCont   <= 1'b0;
            runRate   <= 2'h0;
            convStart <= 1'b0;
            front     <= '0;
        end else begin
            convStart <= 1'b0;
            if (isCmd && (byteVal == CMD_RESET || byteVal == CMD_PDOWN)) begin
                state <= ST_IDLE;
                timer <= 20'h0;
            end else if (isCmd && byteVal == CMD_START) begin
                // mode and rate captured at start
                runCont <= cfg.contMode;
                runRate <= cfg.rate;
                front   <= route(cfg);
                state   <= ST_DELAY;
                timer   <= 20'(START_DLY_CYC);
            end else begin
                case (state)
                    ST_IDLE: begin
                        timer <= 20'h0;
                    end
                    ST_DELAY: begin
                        if (timer == 20'h1) begin
                            state     <= ST_CONV;
                            timer     <= convLen(runRate, runCont);
                            convStart <= 1'b1;
                        end else begin
                            timer <= timer - 20'h1;
                        end
                    end
                    ST_CONV: begin
                        if (timer != 20'h1) begin
                            timer <= timer - 20'h1;
                        end else if (runCont) begin
                            timer     <= convLen(runRate, runCont);
                            convStart <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                            timer <= 20'h0;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        timer <= 20'h0;
                    end
                endcase
            end
        end
    end

    // idle means powered down between single-shot requests
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            convActive <= 1'b0;
        end else begin
            convActive <= (state != ST_IDLE);
        end
    end

    // finished code stored in one step
    acc_result_buffer u_buf (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wrEn    (convDone),
        .wrData  (coreData),
        .rdData  (bufData)
    );

    // fresh flag: a completion in the same cycle as a read keeps it set
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dataFresh <= 1'b0;
        end else if (convDone) begin
            dataFresh <= 1'b1;
        end else if (isCmd && byteVal == CMD_RDATA) begin
            dataFresh <= 1'b0;
        end
    end

    // only the two read codes reply; any other byte leaves the reply untouched
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            replyData  <= '0;
            replyValid <= 1'b0;
        end else begin
            replyValid <= 1'b0;
            if (isCmd && byteVal == CMD_RDATA) begin
                replyData  <= bufData;
                replyValid <= 1'b1;
            end else if (isCmd && byteVal == CMD_RREG) begin
                replyData  <= {16'h0000, cfg};
                replyValid <= 1'b1;
            end
        end
    end

endmodule

// >>> sim/acc_control_asserts.sv
// acc_control_asserts: port-level timing and steering checks of acc_control
// assumes one sys_clk domain and the low-active asynchronous reset nrst
`timescale 1ns/1ns
module acc_control_asserts
    import acc_pkg::*;
(
    input wire logic                sys_clk,     // system clock
    input wire logic                nrst,        // async reset, active low
    input wire logic                sclPin,      // serial clock pin
    input wire logic                sdaPin,      // serial data pin
    input wire logic                framePin,    // frame pin
    input wire logic [RESULT_W-1:0] coreData,    // core code
    input wire acc_front_t          front,       // analog steering
    input wire logic                convActive,  // converter running
    input wire logic                convStart,   // start pulse
    input wire logic                dataFresh,   // unread result
    input wire logic [RESULT_W-1:0] replyData,   // read-back word
    input wire logic                replyValid   // reply pulse
);
    // one clock domain, so one default clock and disable
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    latch_edge_a: assert property (replyValid |-> !sclPin && !$past(sclPin, 3))
        else $error("reply without a settled serial clock fall");
    reply_pulse_a: assert property (replyValid |=> !replyValid)
        else $error("reply pulse longer than one cycle");
    reply_hold_a: assert property ($changed(replyData) |-> replyValid)
        else $error("read-back word changed without a reply");
    start_gap_a: assert property (convStart |=> !convStart [*8])
        else $error("conversion starts too close together");
    start_live_a: assert property (convStart |-> convActive)
        else $error("conversion started while idle");
    fresh_end_a: assert property ($rose(dataFresh) |-> $past(convActive))
        else $error("fresh result without a running conversion");
    front_load_a: assert property ($changed(front) |-> ##1 convActive)
        else $error("steering changed outside a start");
    gnd_pos_a: assert property (front.gndSwitch |-> front.posSel < IN_MID)
        else $error("ground switch closed on a non-pin input");
    mid_pair_a: assert property (front.posSel == IN_MID |-> front.negSel == IN_MID && !front.gndSwitch)
        else $error("mid supply not on both inputs");
endmodule

bind acc_control acc_control_asserts chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .sclPin(sclPin), .sdaPin(sdaPin), .framePin(framePin),
    .coreData(coreData), .front(front), .convActive(convActive), .convStart(convStart),
    .dataFresh(dataFresh), .replyData(replyData), .replyValid(replyValid)
);

// >>> sim/acc_host_model.sv
// acc_host_model: serial host that frames command and data bytes
// assumes address decode is done, so a frame starts with the clock already low
`timescale 1ns/1ns
module acc_host_model (
    input  wire logic sys_clk,   // system clock
    output logic      sclPin,    // serial clock, pulled high when idle
    output logic      sdaPin,    // serial data, pulled high when released
    output logic      framePin   // high while the device is addressed
);
    // bus idle: both lines float to their pull-ups
    initial begin
        sclPin = 1'b1;
        sdaPin = 1'b1;
        framePin = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // whole bytes, msb first
    // the long low phase after each fall gives the latch time to settle
    task automatic frame(input logic [15:0] w, input int nb);
        sclPin <= 1'b0;
        idle(4);
        framePin <= 1'b1;
        idle(4);
        for (int i = 15; i >= 16 - 8 * nb; i--) begin
            sdaPin <= w[i];
            idle(4);
            sclPin <= 1'b1;
            idle(4);
            sclPin <= 1'b0;
            idle(8);
        end
        framePin <= 1'b0;
        sdaPin <= 1'b1;
        idle(2);
        sclPin <= 1'b1;
        idle(4);
    endtask
endmodule

// >>> sim/acc_control_tb.sv
// acc_control_tb: command-level scenarios for the conversion mode control
// assumes the host model drives the serial pins and short conversion counts
`timescale 1ns/1ns
module acc_control_tb
    import acc_pkg::*;
;

    // short conversion lengths, per rate code 0..3
    localparam int SS_N [4] = '{30, 40, 50, 60};
    localparam int CT_N [4] = '{22, 33, 44, 55};
    localparam logic [2:0] POS_E [8] = '{3'h0, 3'h2, 3'h1, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    localparam logic [2:0] NEG_E [8] = '{3'h1, 3'h3, 3'h2, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4};

    logic                sys_clk;     // system clock
    logic                nrst;        // reset, active low
    logic                sclPin;      // serial clock from host
    logic                sdaPin;      // serial data from host
    logic                framePin;    // frame from host
    logic [RESULT_W-1:0] coreData;    // core code
    acc_front_t          front;       // steering seen
    logic                convActive;  // running
    logic                convStart;   // start pulse
    logic                dataFresh;   // unread result
    logic [RESULT_W-1:0] replyData;   // read-back
    logic                replyValid;  // reply pulse
    int                  err_count;   // mismatches
    int                  n_tests;     // comparisons
    int                  nReply = 0;  // reply pulses seen

    // 10 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    acc_host_model host_u (.sys_clk(sys_clk), .sclPin(sclPin), .sdaPin(sdaPin), .framePin(framePin));

    // reply pulses, counted so that each read shows exactly one
    always @(posedge sys_clk) begin
        if (replyValid === 1'b1) begin
            nReply <= nReply + 1;
        end
    end

    acc_control #(
        .CONT_CYC_20(CT_N[0]), .CONT_CYC_90(CT_N[1]), .CONT_CYC_330(CT_N[2]), .CONT_CYC_1000(CT_N[3]),
        .SS_CYC_20(SS_N[0]), .SS_CYC_90(SS_N[1]), .SS_CYC_330(SS_N[2]), .SS_CYC_1000(SS_N[3])
    ) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .sclPin(sclPin), .sdaPin(sdaPin), .framePin(framePin),
        .coreData(coreData), .front(front), .convActive(convActive), .convStart(convStart),
        .dataFresh(dataFresh), .replyData(replyData), .replyValid(replyValid)
    );

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // sample just after the edge so its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // counts are exact: the sequencer counts whole sys_clk cycles
    task automatic chk_n(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            err_count++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // cycles until convStart (0) or dataFresh (1) is high, bounded
    task automatic wait_flag(input bit which, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
            if (n > 3000) begin
                err_count++;
                $display("unexpected wait expected flag seen timeout");
                give_verdict();
            end
        end while ((which ? dataFresh : convStart) !== 1'b1);
    endtask

    task automatic cmd(input logic [7:0] c);
        host_u.frame({c, 8'h00}, 1);
        tick(4);
    endtask

    task automatic setup(input logic [7:0] cfg);
        host_u.frame({CMD_WREG, cfg}, 2);
        tick(4);
    endtask

    task automatic t_regs();
        int base;
        // a data byte equal to a command code must not act
        setup(CMD_START);
        cmd(CMD_RREG);
        chk_v("data byte as command", 32'h0, convActive);
        chk_v("cfg from data byte", 32'h08, replyData);
        setup(8'ha5);
        base = nReply;
        cmd(CMD_RREG);
        chk_v("cfg readback", 32'h0000a5, replyData);
        chk_n("reply pulses", base + 1, nReply);
        cmd(8'hff);
        chk_n("reply after unknown code", base + 1, nReply);
        cmd(CMD_RREG);
        chk_v("cfg after unknown code", 32'h0000a5, replyData);
        cmd(CMD_RESET);
        cmd(CMD_RREG);
        chk_v("cfg after reset command", 32'h0, replyData);
    endtask

    task automatic t_single();
        int n;
        setup(8'h0c);
        @(posedge sys_clk);
        coreData <= 24'h5a3c96;
        cmd(CMD_START);
        wait_flag(0, n);
        wait_flag(1, n);
        chk_n("single-shot length", SS_N[3], n);
        coreData <= 24'h0f0f0f;
        tick(400);
        chk_v("idle after single-shot", 32'h0, convActive);
        chk_v("fresh before read", 32'h1, dataFresh);
        cmd(CMD_RDATA);
        chk_v("single-shot result", 32'h5a3c96, replyData);
        chk_v("fresh after read", 32'h0, dataFresh);
    endtask

    task automatic t_cont();
        int n;
        for (int r = 0; r < 4; r++) begin
            setup({3'h1, 1'b0, 2'(r), 1'b1, 1'b0});
            @(posedge sys_clk);
            coreData <= 24'h100000 + 24'(r);
            cmd(CMD_START);
            wait_flag(0, n);
            wait_flag(0, n);
            chk_n("continuous interval", CT_N[r], n);
            cmd(CMD_RDATA);
            chk_v("latest result", 32'h100000 + r, replyData);
            chk_v("still converting", 32'h1, convActive);
            if (r < 3) begin
                cmd(CMD_PDOWN);
                chk_v("idle after power down", 32'h0, convActive);
            end
        end
        // a mode change waits for the next start
        setup(8'h20);
        tick(200);
        chk_v("mode held until start", 32'h1, convActive);
        cmd(CMD_START);
        tick(400);
        chk_v("single after restart", 32'h0, convActive);
    endtask

    task automatic t_mux();
        for (int s = 0; s < 8; s++) begin
            setup({3'(s), s[0], 3'h0, s[1]});
            cmd(CMD_START);
            chk_v("positive select", POS_E[s], front.posSel);
            chk_v("negative select", NEG_E[s], front.negSel);
            chk_v("ground switch", s >= 3 && s <= 6, front.gndSwitch);
            chk_v("gain four", s[0], front.gainFour);
            chk_v("reference select", s[1], front.extRef);
            cmd(CMD_PDOWN);
        end
    endtask

    // main sequence
    initial begin
        err_count = 0;
        n_tests = 0;
        nrst = 1'b0;
        coreData = '0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        tick(5);
        t_regs();
        t_single();
        t_cont();
        t_mux();
        give_verdict();
    end
endmodule
